// [design/channel_interface_tag_control.sv]
`timescale 1ns/100ps
`default_nettype none
module channel_interface_tag_control
   import chan_pkg::*;
#(
   parameter int SELRST_CYCLES = SELRST_CYC
) (
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   // microword port
   input  wire logic        UOP_VALID,
   input  wire uop_t        UOP,
   output logic             UOP_READY,
   output logic [0:7]       RD_DATA,
   output logic             RD_VALID,
   // channel interface
   input  wire in_tags_t    IN_TAGS,
   input  wire logic [0:7]  BUS_IN,
   input  wire logic        BUS_IN_P,
   output var out_tags_t    OUT_TAGS,
   output logic [0:7]       BUS_OUT,
   output logic             BUS_OUT_P,
   // traps and checks
   output logic             LOWPRI_INHIBIT,
   input  wire logic        MACHINE_CHECK,
   input  wire logic        CHECK_LOGGED,
   input  wire logic        PSW_MC_MASK,
   output logic             MC_TRAP,
   output logic             TRAP_MASK_BIT,
   output logic             CLOCK_STOP,
   output logic             ERROR_LIGHT,
   // logout
   input  wire logic        IFC_CHECK,
   input  wire logic [0:7]  TRAP_PRIORITY,
   input  wire logic [0:7]  BRANCH_COND,
   input  wire logic        SELECTOR_MODE,
   input  wire logic [0:3]  MPX_FUNC,
   input  wire logic        CSW_DIRECT,
   output logic             LOG_VALID,
   output logic [15:0]      LOG_ADDR,
   output logic [0:7]       LOG_DATA,
   input  wire logic        LOG_READY
);

   typedef enum logic [1:0] {
      L_IDLE = 2'b01,
      L_RUN  = 2'b10
   } log_state_t;

   function automatic logic is_bus(input logic [3:0] sel);
      is_bus = (sel == SEL_BUS);
   endfunction

   // reset release
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // state
   logic [0:7]  tag_q;
   logic [0:7]  tag_d;
   logic [0:7]  latch_q;
   logic [0:7]  latch_d;
   logic        bufd_q;
   logic        perr_q;
   logic [10:0] selrst_cnt_q;
   logic [0:7]  bus_out_q;
   logic        bus_out_p_q;
   logic [0:7]  dev_addr_q;
   logic [0:7]  rd_q;
   logic        rd_valid_q;
   logic        trap_mask_q;
   logic        stop_q;
   logic        mc_trap_q;
   logic [11:0] tick_q;
   logic [4:0]  tmo_q;
   logic [5:0]  errcnt_q;
   logic [0:7]  log_q [0:LOG_BYTES-1];
   logic [2:0]  log_idx_q;
   log_state_t  log_state_q;

   // microword decode
   wire out_req   = UOP_VALID & is_bus(UOP.sel) & UOP.to_if
                    & ((UOP.op == OP_STORE) | (UOP.op == OP_MOVE));     // RULE13
   wire buf_ready;
   wire go        = UOP_VALID & UOP_READY;
   wire is_sr     = (UOP.op == OP_SETRST);
   wire wr_tag    = go & is_sr & (UOP.sel == SEL_TAG);
   wire wr_latch  = go & is_sr & (UOP.sel == SEL_LATCH);
   wire rd_req    = go & ~is_sr & ~out_req;
   wire rd_bus    = rd_req & is_bus(UOP.sel);
   assign UOP_READY = ~out_req | buf_ready;

   // parity and tag views
   wire bus_in_bad = ~(^{BUS_IN, BUS_IN_P});                            // RULE8
   wire diag_rst   = tag_q[TAG_DIAG];
   wire sel_done   = tag_q[TAG_SELRST] & (selrst_cnt_q == 11'(SELRST_CYCLES - 1));
   wire svc_vis    = IN_TAGS.svc_in & ~(tag_q[TAG_CMD] | tag_q[TAG_SVC]);  // RULE11
   wire sts_vis    = IN_TAGS.sts_in & ~(tag_q[TAG_CMD] | tag_q[TAG_SVC]);  // RULE11
   wire sup_out    = latch_q[LAT_SUPP] | latch_q[LAT_IB];                  // RULE9

   wire [0:7] latch_view = {latch_q[LAT_CHAIN], bufd_q, latch_q[LAT_BURST], perr_q,
                            tag_q[TAG_INIT], latch_q[LAT_IB], tag_q[TAG_INIT],
                            latch_q[LAT_SUPP]};                          // RULE7
   wire [0:7] in_view    = {IN_TAGS.adr_in, ~IN_TAGS.sel_in, svc_vis, sts_vis,
                            IN_TAGS.op_in, ~IN_TAGS.req_in, latch_q[LAT_ID],
                            latch_q[LAT_DIAG]};                          // RULE10
   wire [0:7] out_view   = {~tag_q[TAG_SELRST], tag_q[TAG_SVC], tag_q[TAG_ADR],
                            tag_q[TAG_CMD], 1'b0, tag_q[TAG_SEL], 1'b0, sup_out};  // RULE6

   wire [0:7] rd_mux = (UOP.sel == SEL_LATCHVIEW) ? latch_view :
                       (UOP.sel == SEL_INVIEW)    ? in_view    :
                       (UOP.sel == SEL_OUTVIEW)   ? out_view   :
                       is_bus(UOP.sel)            ? BUS_IN     :            // RULE12
                       8'h00;

   // tag next value
   always_comb begin
      tag_d = tag_q;
      if (wr_tag) begin
         tag_d              = UOP.k;                                     // RULE1
         tag_d[TAG_SELRST]  = tag_q[TAG_SELRST] | UOP.k[TAG_SELRST];     // RULE5
         tag_d[7]           = 1'b0;
      end
      if (sel_done) begin
         tag_d[TAG_SELRST] = 1'b0;                                       // RULE2
      end
   end

   // latch next value
   always_comb begin
      latch_d = latch_q;
      if (wr_latch) begin
         latch_d = UOP.k & LATCH_WMASK;                                  // RULE14
      end
      if (diag_rst) begin
         latch_d = LATCH_RESET;                                          // RULE4
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tag_q        <= TAG_RESET;
         latch_q      <= LATCH_RESET;
         bufd_q       <= 1'b0;
         perr_q       <= 1'b0;
         selrst_cnt_q <= 11'h000;
      end else begin
         tag_q   <= tag_d;
         latch_q <= latch_d;
         if (diag_rst) begin
            bufd_q <= 1'b0;                                              // RULE4
            perr_q <= 1'b0;
         end else begin
            bufd_q <= bufd_q | (wr_latch & UOP.k[LAT_BUFD]);             // RULE15
            perr_q <= (rd_bus & bus_in_bad)
                      | (perr_q & ~(wr_latch & ~UOP.k[LAT_BUFD]));       // RULE8 RULE15
         end
         if (wr_tag & UOP.k[TAG_SELRST]) begin
            selrst_cnt_q <= 11'h000;
         end else if (tag_q[TAG_SELRST]) begin
            selrst_cnt_q <= selrst_cnt_q + 11'h001;                      // RULE2
         end
      end
   end

   // outbound byte path
   wire       buf_valid;
   wire [0:7] buf_data;
   wire       drain = ~(tag_q[TAG_SVC] | tag_q[TAG_ADR] | tag_q[TAG_CMD]);

   out_buffer #(
      .WIDTH (BUF_WIDTH)
   ) u_out_buffer (
      .clk       (SYS_CLK),
      .rst_n     (rst_n_q),
      .in_valid  (out_req),
      .in_ready  (buf_ready),
      .in_data   (UOP.wdata),
      .out_valid (buf_valid),
      .out_ready (drain),
      .out_data  (buf_data)
   );

   always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bus_out_q   <= 8'h00;
         bus_out_p_q <= 1'b1;
         dev_addr_q  <= 8'h00;
         rd_q        <= 8'h00;
         rd_valid_q  <= 1'b0;
      end else begin
         if (buf_valid & drain) begin
            bus_out_q   <= buf_data;                                     // RULE13
            bus_out_p_q <= ~(^buf_data);
         end
         if (tag_d[TAG_ADR] & ~tag_q[TAG_ADR]) begin
            dev_addr_q <= bus_out_q;                                     // RULE22
         end
         rd_valid_q <= rd_req;
         if (rd_req) begin
            rd_q <= rd_mux;
         end
      end
   end

   // checks and machine-check trap
   always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         trap_mask_q <= 1'b0;
         stop_q      <= 1'b0;
         mc_trap_q   <= 1'b0;
      end else begin
         trap_mask_q <= MACHINE_CHECK | (trap_mask_q & ~CHECK_LOGGED);   // RULE16
         stop_q      <= stop_q | (MACHINE_CHECK & trap_mask_q);          // RULE16
         mc_trap_q   <= MACHINE_CHECK & PSW_MC_MASK;                     // RULE17
      end
   end

   // selector timeout counter
   wire seq_active = tag_q[TAG_SVC] | tag_q[TAG_ADR] | tag_q[TAG_CMD];
   wire tick       = (tick_q == 12'(TMO_TICK_CYC - 1));

   always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tick_q <= 12'h000;
         tmo_q  <= 5'h00;
      end else begin
         tick_q <= (tick | ~seq_active) ? 12'h000 : tick_q + 12'h001;
         if (~seq_active) begin
            tmo_q <= 5'h00;
         end else if (tick & (tmo_q != 5'h1f)) begin
            tmo_q <= tmo_q + 5'h01;                                      // RULE21
         end
      end
   end

   // unit identification
   wire [0:7] uid0 = SELECTOR_MODE ? {UID_SELECT, tmo_q, CSW_DIRECT}     // RULE20 RULE21
                                   : {UID_MPX, MPX_FUNC, CSW_DIRECT};    // RULE22
   wire [5:0] errcnt_next = errcnt_q + 6'h01;

   // interface control check logout
   wire log_start = IFC_CHECK & (log_state_q == L_IDLE);
   wire log_step  = (log_state_q == L_RUN) & LOG_READY;

   always_ff @(posedge SYS_CLK) begin
      if (log_start) begin
         log_q[0] <= TRAP_PRIORITY;                                      // RULE18
         log_q[1] <= BRANCH_COND;
         log_q[2] <= latch_view;
         log_q[3] <= {ERRCNT_HIGH, errcnt_next};                         // RULE19
         log_q[4] <= in_view;
         log_q[5] <= out_view;
         log_q[6] <= uid0;
         log_q[7] <= dev_addr_q;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         log_state_q <= L_IDLE;
         log_idx_q   <= 3'h0;
         errcnt_q    <= 6'h00;
      end else begin
         unique case (log_state_q)
            L_IDLE: begin
               if (log_start) begin
                  log_state_q <= L_RUN;
                  log_idx_q   <= 3'h0;
                  errcnt_q    <= errcnt_next;
               end
            end
            L_RUN: begin
               if (log_step) begin
                  log_idx_q <= log_idx_q + 3'h1;
                  if (log_idx_q == 3'(LOG_BYTES - 1)) begin
                     log_state_q <= L_IDLE;
                  end
               end
            end
            default: begin
               log_state_q <= L_IDLE;
            end
         endcase
      end
   end

   // outputs
   assign LOG_VALID      = (log_state_q == L_RUN);
   assign LOG_ADDR       = LOG_BASE | {13'h0000, log_idx_q};             // RULE18
   assign LOG_DATA       = log_q[log_idx_q];
   assign RD_DATA        = rd_q;
   assign RD_VALID       = rd_valid_q;
   assign BUS_OUT        = bus_out_q;
   assign BUS_OUT_P      = bus_out_p_q;
   assign LOWPRI_INHIBIT = tag_q[TAG_INIT];                              // RULE3
   assign MC_TRAP        = mc_trap_q;
   assign TRAP_MASK_BIT  = trap_mask_q;
   assign CLOCK_STOP     = stop_q;
   assign ERROR_LIGHT    = stop_q;

   assign OUT_TAGS.op_out  = ~tag_q[TAG_SELRST];                         // RULE5
   assign OUT_TAGS.svc_out = tag_q[TAG_SVC];
   assign OUT_TAGS.adr_out = tag_q[TAG_ADR];
   assign OUT_TAGS.cmd_out = tag_q[TAG_CMD];
   assign OUT_TAGS.sel_out = tag_q[TAG_SEL];
   assign OUT_TAGS.sup_out = sup_out;

endmodule
`default_nettype wire

// [design/chan_pkg.sv]
// Summary of operation
// RULE1 - tag word sets 1 bits, clears 0 bits; set/reset bit ignored
// RULE2 - selective reset bit 0 drops op-out for 6 microseconds
// RULE3 - initial-selection tag bit 4 inhibits low-priority traps
// RULE4 - diagnostic reset tag bit 6 clears the channel latches
// RULE5 - bit 0 set-only inverted op-out; bits 1,2,3,5 drive out-tags
// RULE6 - out-tag view: op-out, out-tags in bits 1,2,3,5, suppress-out bit 7
// RULE7 - latch view: chain, buffered, burst, parity, init-sel, int, inhibit, suppress
// RULE8 - bad bus-in parity sets parity-error latch, view bit 3
// RULE9 - suppress latch bit 7 marks command chaining and command fetch
// RULE10 - in-tag view: address, not-select, service, status, op-in, not-request, id, diag
// RULE11 - service-in, status-in show only until command-out or service-out
// RULE12 - inbound byte reads bus-in lines 0 to 7 in bits 0 to 7
// RULE13 - store/move words to the interface load the outbound byte
// RULE14 - latch register: chain, id, burst, diagnostic, interrupt buffer, suppress
// RULE15 - latch write bit 3: 1 sets buffered-device, 0 clears parity error
// RULE16 - check sets trap mask bit; second check stops clock, lights error
// RULE17 - machine-check trap only when status word mask bit is on
// RULE18 - interface check logs eight bytes from location 80 in fixed order
// RULE19 - logged error count: 6 bits in 2-7, bits 0-1 ones
// RULE20 - unit id bits 0-2: 000 integrated, 001 multiplexer, 01x selector, 100 comms
// RULE21 - selector unit id bits 2-6 count interface sequence timeout
// RULE22 - unit id bit 7 marks direct status; byte 1 holds device address
// RULE23 - control unit answers address with op-in, address-in, then status and data
package chan_pkg;

   // microword ops
   typedef enum logic [1:0] {
      OP_SETRST = 2'h0,
      OP_BRANCH = 2'h1,
      OP_STORE  = 2'h2,
      OP_MOVE   = 2'h3
   } uop_op_t;

   typedef struct packed {
      uop_op_t    op;
      logic       to_if;   // towards the interface
      logic [3:0] sel;     // external source decode or set/reset target
      logic [0:7] k;       // immediate field
      logic [0:7] wdata;   // storage/move data
   } uop_t;

   typedef struct packed {
      logic adr_in;
      logic sel_in;
      logic svc_in;
      logic sts_in;
      logic op_in;
      logic req_in;
   } in_tags_t;

   typedef struct packed {
      logic op_out;
      logic svc_out;
      logic adr_out;
      logic cmd_out;
      logic sel_out;
      logic sup_out;
   } out_tags_t;

   // targets and decodes
   localparam logic [3:0] SEL_TAG       = 4'hb;
   localparam logic [3:0] SEL_LATCH     = 4'ha;
   localparam logic [3:0] SEL_LATCHVIEW = 4'hc;
   localparam logic [3:0] SEL_INVIEW    = 4'hd;
   localparam logic [3:0] SEL_OUTVIEW   = 4'he;
   localparam logic [3:0] SEL_BUS       = 4'hf;

   // tag register bits
   localparam int TAG_SELRST = 0;
   localparam int TAG_SVC    = 1;
   localparam int TAG_ADR    = 2;
   localparam int TAG_CMD    = 3;
   localparam int TAG_INIT   = 4;
   localparam int TAG_SEL    = 5;
   localparam int TAG_DIAG   = 6;

   // latch register bits
   localparam int LAT_CHAIN = 0;
   localparam int LAT_ID    = 1;
   localparam int LAT_BURST = 2;
   localparam int LAT_BUFD  = 3;
   localparam int LAT_DIAG  = 4;
   localparam int LAT_IB    = 5;
   localparam int LAT_SUPP  = 7;

   localparam logic [0:7] TAG_RESET   = 8'h00;
   localparam logic [0:7] LATCH_RESET = 8'h00;
   localparam logic [0:7] LATCH_WMASK = 8'hed;

   // timing
   localparam int CLK_NS     = 5;
   localparam int SELRST_NS  = 6000;
   localparam int SELRST_CYC = (SELRST_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMO_TICK_CYC = 4000;

   // logout
   localparam logic [15:0] LOG_BASE    = 16'h0080;
   localparam int          LOG_BYTES   = 8;
   localparam logic [1:0]  ERRCNT_HIGH = 2'h3;
   localparam logic [2:0]  UID_MPX     = 3'h1;
   localparam logic [1:0]  UID_SELECT  = 2'h1;

   localparam int BUF_WIDTH = 8;

endpackage

// [design/out_buffer.sv]
`timescale 1ns/100ps
`default_nettype none
module out_buffer #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   logic [WIDTH-1:0] mem_q [0:1];
   logic             wptr_q;
   logic             rptr_q;
   logic [1:0]       count_q;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   assign in_ready  = (count_q != 2'h2);
   assign out_valid = (count_q != 2'h0);
   assign out_data  = mem_q[rptr_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wptr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_q  <= 1'b0;
         rptr_q  <= 1'b0;
         count_q <= 2'h0;
      end else begin
         wptr_q  <= wptr_q ^ push;
         rptr_q  <= rptr_q ^ pop;
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule
`default_nettype wire

// [tb/tag_control_props.sv]
`timescale 1ns/100ps
`default_nettype none
module tag_control_props
   import chan_pkg::*;
#(
   parameter int SELRST_CYCLES = SELRST_CYC
) (
   // clock and reset
   input wire logic        SYS_CLK,
   input wire logic        RST_N,
   // microword port
   input wire logic        UOP_VALID,
   input wire uop_t        UOP,
   input wire logic        UOP_READY,
   input wire logic        RD_VALID,
   // channel interface
   input wire out_tags_t   OUT_TAGS,
   input wire logic [0:7]  BUS_OUT,
   input wire logic        BUS_OUT_P,
   // traps and checks
   input wire logic        LOWPRI_INHIBIT,
   input wire logic        MACHINE_CHECK,
   input wire logic        PSW_MC_MASK,
   input wire logic        MC_TRAP,
   input wire logic        TRAP_MASK_BIT,
   input wire logic        CLOCK_STOP,
   input wire logic        ERROR_LIGHT,
   // logout
   input wire logic        IFC_CHECK,
   input wire logic        SELECTOR_MODE,
   input wire logic        CSW_DIRECT,
   input wire logic        LOG_VALID,
   input wire logic [15:0] LOG_ADDR,
   input wire logic [0:7]  LOG_DATA,
   input wire logic        LOG_READY
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   wire         take = UOP_VALID && UOP_READY;
   wire         tag_take = take && UOP.op == OP_SETRST && UOP.sel == SEL_TAG;
   wire         bus_wr = UOP.to_if && UOP.sel == SEL_BUS && (UOP.op == OP_STORE || UOP.op == OP_MOVE);
   wire         rd_take = take && UOP.op != OP_SETRST && !bus_wr;
   logic [15:0] low_q;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N)
         low_q <= 16'h0000;
      else if (OUT_TAGS.op_out)
         low_q <= 16'h0000;
      else
         low_q <= low_q + 16'h0001;
   end
   AST_TAG_OUT: assert property (tag_take |=> OUT_TAGS.svc_out == $past(UOP.k[1]) &&
      OUT_TAGS.adr_out == $past(UOP.k[2]) && OUT_TAGS.cmd_out == $past(UOP.k[3]) &&
      OUT_TAGS.sel_out == $past(UOP.k[5])) else $error("out tags wrong");
   AST_INHIBIT: assert property (tag_take |=> LOWPRI_INHIBIT == $past(UOP.k[4]))
      else $error("inhibit wrong");
   AST_SELRST_LEN: assert property ($rose(OUT_TAGS.op_out) |->
      low_q >= SELRST_CYCLES - 1 && low_q <= SELRST_CYCLES + 1) else $error("drop length");
   AST_RD_VALID: assert property (RD_VALID == $past(rd_take)) else $error("read timing");
   AST_MC_TRAP: assert property (MC_TRAP |-> $past(MACHINE_CHECK) && $past(PSW_MC_MASK))
      else $error("stray trap");
   AST_MASK_SET: assert property (MACHINE_CHECK |=> TRAP_MASK_BIT) else $error("mask not set");
   AST_STOP: assert property (MACHINE_CHECK && TRAP_MASK_BIT |=> CLOCK_STOP && ERROR_LIGHT)
      else $error("no stop");
   AST_LOG_START: assert property (IFC_CHECK && !LOG_VALID |=> LOG_VALID && LOG_ADDR == 16'h0080)
      else $error("logout start");
   AST_LOG_HOLD: assert property (LOG_VALID && !LOG_READY |=> LOG_VALID && $stable(LOG_ADDR) &&
      $stable(LOG_DATA)) else $error("byte not held");
   AST_LOG_STEP: assert property (LOG_VALID && LOG_READY && LOG_ADDR != 16'h0087 |=>
      LOG_VALID && LOG_ADDR == $past(LOG_ADDR) + 16'h0001) else $error("logout step");
   AST_ERRCNT: assert property (LOG_VALID && LOG_ADDR == 16'h0083 |-> LOG_DATA[0:1] == 2'h3)
      else $error("count bits");
   AST_UID: assert property (LOG_VALID && LOG_ADDR == 16'h0086 |-> LOG_DATA[7] == CSW_DIRECT &&
      (SELECTOR_MODE ? LOG_DATA[0:1] == 2'h1 : LOG_DATA[0:2] == 3'h1)) else $error("unit id wrong");
   AST_PARITY: assert property (^{BUS_OUT, BUS_OUT_P} == 1'b1) else $error("bus parity");
endmodule
bind channel_interface_tag_control tag_control_props #(.SELRST_CYCLES(SELRST_CYCLES)) props (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .UOP_VALID(UOP_VALID), .UOP(UOP), .UOP_READY(UOP_READY),
   .RD_VALID(RD_VALID), .OUT_TAGS(OUT_TAGS), .BUS_OUT(BUS_OUT), .BUS_OUT_P(BUS_OUT_P),
   .LOWPRI_INHIBIT(LOWPRI_INHIBIT), .MACHINE_CHECK(MACHINE_CHECK), .PSW_MC_MASK(PSW_MC_MASK),
   .MC_TRAP(MC_TRAP), .TRAP_MASK_BIT(TRAP_MASK_BIT), .CLOCK_STOP(CLOCK_STOP), .ERROR_LIGHT(ERROR_LIGHT),
   .IFC_CHECK(IFC_CHECK), .SELECTOR_MODE(SELECTOR_MODE), .CSW_DIRECT(CSW_DIRECT), .LOG_VALID(LOG_VALID),
   .LOG_ADDR(LOG_ADDR), .LOG_DATA(LOG_DATA), .LOG_READY(LOG_READY));
`default_nettype wire

// [tb/cu_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cu_model
   import chan_pkg::*;
#(
   parameter logic [0:7] DEV = 8'h3a,
   parameter logic [0:7] STS = 8'h0c,
   parameter logic [0:7] DAT = 8'h5e
) (
   // channel side
   input  wire logic       clk,
   input  wire out_tags_t  ot,
   input  wire logic       bad_par,
   output var in_tags_t    it,
   output logic [0:7]      bus_in,
   output logic            bus_in_p
);
   logic [2:0] st_q = 3'h0;
   logic [0:7] idle_q = 8'h55;
   always_ff @(posedge clk) begin
      idle_q <= ~bus_in;
      if (!ot.sel_out)
         st_q <= 3'h0;
      else if (st_q == 3'h0 && ot.adr_out)
         st_q <= 3'h1;
      else if (st_q == 3'h1 && !ot.adr_out)
         st_q <= 3'h2;
      else if (st_q == 3'h2 && ot.cmd_out)
         st_q <= 3'h3;
      else if (st_q == 3'h3 && ot.svc_out)
         st_q <= 3'h4;
   end
   assign it = {st_q == 3'h2, st_q != 3'h0, st_q == 3'h4, st_q == 3'h3, st_q != 3'h0, 1'b0};
   // idle bus toggles
   assign bus_in = (st_q == 3'h2) ? DEV : (st_q == 3'h3) ? STS : (st_q == 3'h4) ? DAT : idle_q;
   assign bus_in_p = ~^bus_in ^ bad_par;
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import chan_pkg::*;
   localparam int SELR = 8;
   localparam logic [0:7] DEV = 8'h3a;
   localparam logic [0:7] STS = 8'h0c;
   localparam logic [0:7] DAT = 8'h5e;
   logic        SYS_CLK = 1'b0;
   logic        RST_N = 1'b0;
   logic        UOP_VALID = 1'b0;
   uop_t        UOP = '0;
   logic        UOP_READY, RD_VALID, BUS_IN_P, BUS_OUT_P, LOWPRI_INHIBIT, MC_TRAP;
   logic        TRAP_MASK_BIT, CLOCK_STOP, ERROR_LIGHT, LOG_VALID;
   logic [0:7]  RD_DATA, BUS_IN, BUS_OUT, LOG_DATA;
   in_tags_t    IN_TAGS;
   out_tags_t   OUT_TAGS;
   logic [15:0] LOG_ADDR;
   logic        MACHINE_CHECK = 1'b0, CHECK_LOGGED = 1'b0, PSW_MC_MASK = 1'b1, IFC_CHECK = 1'b0;
   logic        SELECTOR_MODE = 1'b0, CSW_DIRECT = 1'b1, LOG_READY = 1'b0, bad_par = 1'b0;
   logic [0:7]  TRAP_PRIORITY = 8'h81, BRANCH_COND = 8'h3c;
   logic [0:3]  MPX_FUNC = 4'h5;
   int          n_fail = 0;
   int          comparisons = 0;
   channel_interface_tag_control #(.SELRST_CYCLES(SELR)) DUT (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
      .UOP_VALID(UOP_VALID), .UOP(UOP), .UOP_READY(UOP_READY), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
      .IN_TAGS(IN_TAGS), .BUS_IN(BUS_IN), .BUS_IN_P(BUS_IN_P), .OUT_TAGS(OUT_TAGS), .BUS_OUT(BUS_OUT),
      .BUS_OUT_P(BUS_OUT_P), .LOWPRI_INHIBIT(LOWPRI_INHIBIT), .MACHINE_CHECK(MACHINE_CHECK),
      .CHECK_LOGGED(CHECK_LOGGED), .PSW_MC_MASK(PSW_MC_MASK), .MC_TRAP(MC_TRAP), .TRAP_MASK_BIT(TRAP_MASK_BIT),
      .CLOCK_STOP(CLOCK_STOP), .ERROR_LIGHT(ERROR_LIGHT), .IFC_CHECK(IFC_CHECK), .TRAP_PRIORITY(TRAP_PRIORITY),
      .BRANCH_COND(BRANCH_COND), .SELECTOR_MODE(SELECTOR_MODE), .MPX_FUNC(MPX_FUNC), .CSW_DIRECT(CSW_DIRECT),
      .LOG_VALID(LOG_VALID), .LOG_ADDR(LOG_ADDR), .LOG_DATA(LOG_DATA), .LOG_READY(LOG_READY));
   cu_model cu (.clk(SYS_CLK), .ot(OUT_TAGS), .bad_par(bad_par),
      .it(IN_TAGS), .bus_in(BUS_IN), .bus_in_p(BUS_IN_P));
   initial begin
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic uop(input uop_op_t op, input logic ti, input logic [3:0] sel, input logic [0:7] k);
      @(negedge SYS_CLK);
      UOP_VALID = 1'b1;
      UOP = '{op: op, to_if: ti, sel: sel, k: k, wdata: k};
      #1;
      while (UOP_READY !== 1'b1) begin
         @(negedge SYS_CLK);
      end
      @(negedge SYS_CLK);
      UOP_VALID = 1'b0;
   endtask
   task automatic rd(input logic [3:0] sel, input logic [7:0] e);
      uop(OP_BRANCH, 1'b0, sel, 8'h00);
      chk($sformatf("rd %h", sel), e, RD_DATA);
   endtask
   task automatic tag(input logic [0:7] k);
      uop(OP_SETRST, 1'b0, SEL_TAG, k);
      repeat (4) @(negedge SYS_CLK);
   endtask
   task automatic wait_bus(input logic [7:0] e);
      for (int w = 0; w < 20 && BUS_OUT !== e; w++) @(negedge SYS_CLK);
      chk("bus_out", e, BUS_OUT);
   endtask
   task automatic pulse(ref logic s);
      @(negedge SYS_CLK);
      s = 1'b1;
      @(negedge SYS_CLK);
      s = 1'b0;
   endtask
   task automatic logout(input logic [7:0] e [8]);
      pulse(IFC_CHECK);
      for (int i = 0; i < 8; i++) begin
         chk("log_addr", 8'(8'h80 + i), LOG_ADDR[7:0]);
         chk("log_data", e[i], LOG_DATA);
         LOG_READY = 1'b1;
         @(negedge SYS_CLK);
         LOG_READY = 1'b0;
         @(negedge SYS_CLK);
      end
   endtask
   initial begin
      #100000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (10) @(negedge SYS_CLK);
      RST_N = 1'b1;
      repeat (3) @(negedge SYS_CLK);
      rd(SEL_OUTVIEW, 8'h80);
      rd(SEL_INVIEW, 8'h44);
      rd(SEL_LATCHVIEW, 8'h00);
      rd(4'h0, 8'h00);
      uop(OP_STORE, 1'b1, SEL_BUS, DEV);
      wait_bus(DEV);
      tag(8'h24);
      chk("out_tags", 8'h2a, {2'b00, OUT_TAGS});
      tag(8'h04);
      chk("out_tags", 8'h22, {2'b00, OUT_TAGS});
      rd(SEL_INVIEW, 8'h8c);
      rd(SEL_BUS, DEV);
      tag(8'h14);
      rd(SEL_INVIEW, 8'h0c);
      tag(8'h04);
      rd(SEL_INVIEW, 8'h1c);
      rd(SEL_BUS, STS);
      tag(8'h44);
      rd(SEL_INVIEW, 8'h0c);
      rd(SEL_OUTVIEW, 8'hc4);
      rd(SEL_BUS, DAT);
      // service-out parks both entries
      uop(OP_STORE, 1'b1, SEL_BUS, 8'ha1);
      uop(OP_MOVE, 1'b1, SEL_BUS, 8'hb2);
      @(negedge SYS_CLK);
      UOP_VALID = 1'b1;
      UOP = '{op: OP_STORE, to_if: 1'b1, sel: SEL_BUS, k: 8'hc3, wdata: 8'hc3};
      #1;
      chk("uop_ready", 8'h00, 8'(UOP_READY));
      @(negedge SYS_CLK);
      UOP_VALID = 1'b0;
      uop(OP_SETRST, 1'b0, SEL_TAG, 8'h04);
      wait_bus(8'ha1);
      wait_bus(8'hb2);
      bad_par = 1'b1;
      rd(SEL_BUS, DAT);
      bad_par = 1'b0;
      rd(SEL_LATCHVIEW, 8'h10);
      uop(OP_SETRST, 1'b0, SEL_LATCH, 8'h00);
      rd(SEL_LATCHVIEW, 8'h00);
      uop(OP_SETRST, 1'b0, SEL_LATCH, 8'hff);
      rd(SEL_LATCHVIEW, 8'he5);
      rd(SEL_INVIEW, 8'h2f);
      rd(SEL_OUTVIEW, 8'h85);
      tag(8'h06);
      rd(SEL_LATCHVIEW, 8'h00);
      tag(8'h08);
      chk("inhibit", 8'h01, 8'(LOWPRI_INHIBIT));
      rd(SEL_LATCHVIEW, 8'h0a);
      tag(8'h00);
      logout('{8'h81, 8'h3c, 8'h00, 8'hc1, 8'h44, 8'h80, 8'h2b, DEV});
      SELECTOR_MODE = 1'b1;
      logout('{8'h81, 8'h3c, 8'h00, 8'hc2, 8'h44, 8'h80, 8'h41, DEV});
      uop(OP_SETRST, 1'b0, SEL_TAG, 8'h80);
      chk("op_out", 8'h00, 8'(OUT_TAGS.op_out));
      uop(OP_SETRST, 1'b0, SEL_TAG, 8'h00);
      chk("op_out", 8'h00, 8'(OUT_TAGS.op_out));
      for (int n = 0; n < SELR + 8; n++) begin
         if (OUT_TAGS.op_out === 1'b1) begin
            chk("selrst_len", 8'h01, 8'(n >= SELR - 4 && n <= SELR));
            break;
         end
         @(negedge SYS_CLK);
      end
      chk("op_out", 8'h01, 8'(OUT_TAGS.op_out));
      pulse(MACHINE_CHECK);
      chk("mc_trap", 8'h01, 8'(MC_TRAP));
      chk("trap_mask", 8'h01, 8'(TRAP_MASK_BIT));
      pulse(CHECK_LOGGED);
      chk("trap_mask", 8'h00, 8'(TRAP_MASK_BIT));
      PSW_MC_MASK = 1'b0;
      pulse(MACHINE_CHECK);
      chk("mc_trap", 8'h00, 8'(MC_TRAP));
      chk("stops", 8'h00, {6'h00, CLOCK_STOP, ERROR_LIGHT});
      pulse(MACHINE_CHECK);
      chk("stops", 8'h03, {6'h00, CLOCK_STOP, ERROR_LIGHT});
      RST_N = 1'b0;
      @(negedge SYS_CLK);
      chk("reset_tags", 8'h20, {2'b00, OUT_TAGS});
      chk("stops", 8'h00, {6'h00, CLOCK_STOP, ERROR_LIGHT});
      RST_N = 1'b1;
      report_and_stop();
   end
endmodule
`default_nettype wire
